// ### hw/crb_branch_unit.sv
// decode and execute of short conditional relative branches
`timescale 1ns/10ps
`include "crb_defines.svh"
module crb_branch_unit #(
   parameter int PC_WIDTH = 21
) (
   input wire logic CLOCK, // 10 MHz core clock
   input wire logic RSTN, // async reset, low active
   input wire logic CLK_EN, // freezes all state when low
   input wire crb_pkg::crb_word_t INSTR, // fetched word, held per cycle
   input wire logic INSTR_VALID, // word is to be executed
   input wire logic [4:0] STATUS, // flags from the alu
   output logic [PC_WIDTH-1:0] PC, // program counter
   output logic [3:0] PHASE, // one-hot phase_one..phase_four
   output logic IDLE_CYCLE, // forced no-operation cycle
   output logic PC_WRITE, // one phase pulse: counter loaded
   output logic BRANCH_TAKEN, // level per cycle: branch executing
   output logic [4:0] STATUS_OUT // flags passed through unchanged
);
   // the doubled offset needs nine bits; the step constant is 21 wide
   if (PC_WIDTH < 9 || PC_WIDTH > 21) begin
      $error("PC_WIDTH out of range");
   end

   // ****************************************
   // phase sequencing
   // ****************************************
   crb_pkg::crb_phase_t phase;
   crb_pkg::crb_phase_t next_phase;
   crb_pkg::crb_word_t word;
   logic idle;

   always_comb begin
      case (phase)
         crb_pkg::PH_ONE: next_phase = crb_pkg::PH_TWO;
         crb_pkg::PH_TWO: next_phase = crb_pkg::PH_THREE;
         crb_pkg::PH_THREE: next_phase = crb_pkg::PH_FOUR;
         crb_pkg::PH_FOUR: next_phase = crb_pkg::PH_ONE;
         default: next_phase = crb_pkg::PH_ONE;
      endcase
   end

   // ****************************************
   // decode
   // ****************************************
   // zero-clear decode
   wire is_zero_clear = word.opcode == `CRB_OP_ZERO_CLEAR;
   wire is_ovf_clear = word.opcode == `CRB_OP_OVF_CLEAR;
   // encodings of these two are less certain; kept as constants
   wire is_sign_clear = word.opcode == `CRB_OP_SIGN_CLEAR;
   wire is_carry_clear = word.opcode == `CRB_OP_CARRY_CLEAR;
   wire is_branch = is_zero_clear | is_ovf_clear | is_sign_clear
      | is_carry_clear;
   wire cond = (is_zero_clear & ~STATUS[`CRB_FLAG_ZERO])
      | (is_ovf_clear & ~STATUS[`CRB_FLAG_OVF])
      | (is_sign_clear & ~STATUS[`CRB_FLAG_SIGN])
      | (is_carry_clear & ~STATUS[`CRB_FLAG_CARRY]);
   wire [PC_WIDTH-1:0] disp = {{(PC_WIDTH-9){word.offset[7]}},
      word.offset, 1'b0};
   wire [PC_WIDTH-1:0] pc_inc = PC + PC_WIDTH'(`CRB_PC_STEP);
   wire [PC_WIDTH-1:0] target = pc_inc + disp;
   wire at_four = phase == crb_pkg::PH_FOUR;
   wire go = at_four & ~idle & is_branch & cond;
   // a refused word becomes an opcode that decodes as nothing
   wire crb_pkg::crb_word_t next_word = INSTR_VALID ? INSTR
      : crb_pkg::crb_word_t'(16'h0000);

   // ****************************************
   // state
   // ****************************************
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         phase <= crb_pkg::PH_ONE;
         word <= '0;
         idle <= 1'b0;
         PC <= PC_WIDTH'(`CRB_PC_RESET);
         PHASE <= 4'h1;
         IDLE_CYCLE <= 1'b0;
         PC_WRITE <= 1'b0;
         BRANCH_TAKEN <= 1'b0;
         STATUS_OUT <= 5'h00;
      end else if (CLK_EN) begin
         phase <= next_phase;
         PHASE <= next_phase;
         STATUS_OUT <= STATUS;
         if (phase == crb_pkg::PH_TWO && !idle)
            word <= next_word;
         PC_WRITE <= go;
         if (at_four) begin
            // taken branch adds an idle cycle
            idle <= go;
            IDLE_CYCLE <= go;
            BRANCH_TAKEN <= go;
            if (go)
               PC <= target;
            else if (!idle)
               PC <= pc_inc;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // enabled cycles spent in the idle cycle; a held clock enable
   // stretches the idle cycle in time but never in count
   logic [2:0] idle_count;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN)
         idle_count <= 3'h0;
      else if (CLK_EN)
         idle_count <= IDLE_CYCLE ? idle_count + 3'h1 : 3'h0;
   end

   // the three ways an instruction cycle can end in phase_four
   sequence s_branch_go;
      CLK_EN && go;
   endsequence
   sequence s_fall_through;
      CLK_EN && at_four && !idle && !go;
   endsequence
   sequence s_idle_over;
      CLK_EN && at_four && idle;
   endsequence

   AST_TAKEN_TARGET:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_branch_go |=> PC == $past(target))
      else $error("taken target wrong");
   AST_TAKEN_MARKS:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_branch_go |=> PC_WRITE && IDLE_CYCLE && BRANCH_TAKEN)
      else $error("taken branch not marked");
   AST_NOT_TAKEN_STEP:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_fall_through |=> PC == $past(pc_inc))
      else $error("not taken step wrong");
   AST_NOT_TAKEN_QUIET:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_fall_through |=> !PC_WRITE && !IDLE_CYCLE && !BRANCH_TAKEN)
      else $error("not taken branch marked");
   AST_ZERO_SET_BLOCKS:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      at_four && is_zero_clear && STATUS[`CRB_FLAG_ZERO] |-> !go)
      else $error("branch with zero set");
   AST_OVF_SET_BLOCKS:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      at_four && is_ovf_clear && STATUS[`CRB_FLAG_OVF] |-> !go)
      else $error("branch with overflow set");
   AST_ZERO_DECODE:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      at_four && !idle && word.opcode == 8'hE1 && !STATUS[2] |-> go)
      else $error("zero clear not taken");
   AST_OVF_DECODE:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      at_four && !idle && word.opcode == 8'hE5 && !STATUS[3] |-> go)
      else $error("overflow clear not taken");
   AST_NON_BRANCH:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      at_four && !is_branch |-> !go)
      else $error("other word branched");
   AST_DISP_SIGN:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      disp[PC_WIDTH-1] == word.offset[7] && disp[0] == 1'b0)
      else $error("offset not sign extended");
   AST_DISP_VALUE:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      disp[8:1] == word.offset)
      else $error("offset not doubled");

   // ****************************************
   // idle cycle and sequencing checks
   // ****************************************
   // counted in enabled cycles so a held clock enable cannot trip it
   AST_IDLE_LEN:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      IDLE_CYCLE |-> idle_count < `CRB_IDLE_LEN)
      else $error("idle cycle too long");
   AST_IDLE_END:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      $fell(IDLE_CYCLE) |-> idle_count == `CRB_IDLE_LEN)
      else $error("idle cycle length wrong");
   AST_IDLE_HOLDS_PC:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_idle_over |=> PC == $past(PC) && !PC_WRITE)
      else $error("counter moved in idle cycle");
   // the word of the branch itself must survive the idle cycle
   AST_IDLE_REFUSES:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_idle_over |-> word == $past(word, 3))
      else $error("word taken in idle cycle");
   // the pulse may stand longer while the clock enable is low
   AST_WRITE_PHASE:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      PC_WRITE |-> PHASE == 4'h1 && IDLE_CYCLE && BRANCH_TAKEN)
      else $error("counter written off phase");
   AST_WRITE_ONCE:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      PC_WRITE && CLK_EN |=> !PC_WRITE)
      else $error("write pulse too long");
   AST_PHASE_ONE_HOT:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      $onehot(phase) && PHASE == phase)
      else $error("phase not one-hot");
   AST_PHASE_STEP:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      CLK_EN |=> PHASE == {$past(PHASE[2:0]), $past(PHASE[3])})
      else $error("phase skipped");
   AST_FROZEN:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      !CLK_EN |=> $stable(PC) && $stable(PHASE) && $stable(word))
      else $error("state moved while frozen");
   AST_FLAGS_PASS:
   assert property (@(posedge CLOCK) disable iff (!RSTN)
      CLK_EN |=> STATUS_OUT == $past(STATUS))
      else $error("flags changed");
endmodule

// ### pkg/crb_defines.svh
// constants for the conditional relative branch unit
`ifndef CRB_DEFINES_SVH
`define CRB_DEFINES_SVH
`define CRB_OP_ZERO_CLEAR 8'hE1
`define CRB_OP_OVF_CLEAR 8'hE5
`define CRB_OP_SIGN_CLEAR 8'hE7
`define CRB_OP_CARRY_CLEAR 8'hE3
`define CRB_PC_STEP 21'h000002
`define CRB_PC_RESET 21'h000000
`define CRB_FLAG_CARRY 0
`define CRB_FLAG_ZERO 2
`define CRB_FLAG_OVF 3
`define CRB_FLAG_SIGN 4
`define CRB_IDLE_LEN 3'h4
`endif

// ### pkg/crb_pkg.sv
// types for the conditional relative branch unit
package crb_pkg;
   typedef enum logic [3:0] {
      PH_ONE = 4'h1,
      PH_TWO = 4'h2,
      PH_THREE = 4'h4,
      PH_FOUR = 4'h8
   } crb_phase_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] offset;
   } crb_word_t;
endpackage

// ### tb/crb_bench.sv
// self-checking bench for the conditional relative branch unit
`timescale 1ns/10ps
module conditional_relative_branch_bench;
   logic CLOCK, RSTN, CLK_EN, INSTR_VALID, IDLE_CYCLE, PC_WRITE, BRANCH_TAKEN;
   crb_pkg::crb_word_t INSTR;
   logic [4:0] STATUS, STATUS_OUT;
   logic [20:0] PC, exp_pc;
   logic [3:0] PHASE;
   int fails, total_checks;
   crb_branch_unit dut (.CLOCK(CLOCK), .RSTN(RSTN), .CLK_EN(CLK_EN),
      .INSTR(INSTR), .INSTR_VALID(INSTR_VALID), .STATUS(STATUS), .PC(PC),
      .PHASE(PHASE), .IDLE_CYCLE(IDLE_CYCLE), .PC_WRITE(PC_WRITE),
      .BRANCH_TAKEN(BRANCH_TAKEN), .STATUS_OUT(STATUS_OUT));
   initial begin
      CLOCK = 0;
      forever #50 CLOCK = ~CLOCK;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ****
   // one instruction, entered at a phase_one falling edge
   // ****
   task exec(input logic [7:0] op, input logic [7:0] off,
      input logic [4:0] flags, input logic taken);
      INSTR = {op, off};
      STATUS = flags;
      repeat (4) @(negedge CLOCK);
      exp_pc = exp_pc + 21'h2 + (taken ? {{12{off[7]}}, off, 1'b0} : 21'h0);
      chk(PC, exp_pc);
      chk(PHASE, 4'h1);
      chk({PC_WRITE, IDLE_CYCLE, BRANCH_TAKEN}, {3{taken}});
      chk(STATUS_OUT, flags);
      if (taken) begin
         // a branch word offered in the idle cycle must be ignored
         INSTR = {8'hE1, 8'h10};
         STATUS = 5'h00;
         repeat (4) @(negedge CLOCK);
         chk(PC, exp_pc);
         chk({PC_WRITE, IDLE_CYCLE}, 2'b00);
      end
   endtask
   task t_codes;
      logic [7:0] ops [4];
      int bits [4];
      ops = '{8'hE1, 8'hE5, 8'hE7, 8'hE3};
      bits = '{2, 3, 4, 0};
      // only the tested flag differs, so a wrong bit select shows up
      for (int i = 0; i < 4; i++) begin
         exec(ops[i], 8'h03, ~(5'h01 << bits[i]), 1'b1);
         exec(ops[i], 8'hFD, 5'h01 << bits[i], 1'b0);
      end
   endtask
   task t_offsets;
      exec(8'hE1, 8'h80, 5'h00, 1'b1);
      exec(8'hE1, 8'h7F, 5'h00, 1'b1);
      exec(8'hE1, 8'h00, 5'h1B, 1'b1);
      exec(8'hE1, 8'hFF, 5'h04, 1'b0);
   endtask
   task t_other;
      exec(8'h0F, 8'h22, 5'h00, 1'b0);
      INSTR_VALID = 0;
      exec(8'hE1, 8'h22, 5'h00, 1'b0);
      INSTR_VALID = 1;
   endtask
   task t_freeze;
      CLK_EN = 0;
      repeat (5) @(negedge CLOCK);
      chk({PHASE, PC}, {4'h1, exp_pc});
      CLK_EN = 1;
      exec(8'hE5, 8'h40, 5'h00, 1'b1);
   endtask
   initial begin
      RSTN = 0;
      CLK_EN = 1;
      INSTR_VALID = 1;
      INSTR = '0;
      STATUS = '0;
      exp_pc = '0;
      fails = 0;
      total_checks = 0;
      repeat (6) @(negedge CLOCK);
      RSTN = 1;
      t_codes;
      t_offsets;
      t_other;
      t_freeze;
      conclude;
   end
   // about 100 cycles are needed; thirty times that means a hang
   initial begin
      #300000;
      fails++;
      conclude;
   end
endmodule
